// ===== rtl/lcf_pkg.sv
package lcf_pkg;
  localparam int CHANNELS = 32;
  localparam int GROUP_WIDTH = 8;
  localparam int COMP_CHANNELS = 24;
  localparam int NARROW_CHANNELS = 16;
  localparam int RUN_MAX = 255;
  localparam int RUN_WIDTH = 8;
  localparam int MEM_WORDS_DEF = 131072;
  localparam int FIFO_DEPTH_DEF = 32;
  localparam int CLK_HZ_DEF = 125000000;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RATE = 8'h04;
  localparam logic [7:0] OFS_DEPTH = 8'h08;
  localparam logic [7:0] OFS_FILT_AB = 8'h0C;
  localparam logic [7:0] OFS_FILT_CD = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_COUNT = 8'h18;
  localparam logic [7:0] OFS_MEM_ADDR = 8'h1C;
  localparam logic [7:0] OFS_MEM_DATA = 8'h20;

  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_COMP = 2;
  localparam int CTRL_EXT = 3;
  localparam int CTRL_FALL = 4;
  localparam int CTRL_PAUSE = 5;

  localparam int STAT_STATE = 0;
  localparam int STAT_OVF = 2;
  localparam int STAT_NARROW = 3;
  localparam int STAT_EMPTY = 4;

  localparam logic [1:0] FILT_DONT_CARE = 2'h0;
  localparam logic [1:0] FILT_HIGH = 2'h1;
  localparam logic [1:0] FILT_LOW = 2'h2;
  localparam logic [31:0] FILT_RST = 32'h00000000;

  localparam int RATE_CNT = 18;
  localparam int unsigned RATE_HZ [RATE_CNT] = '{
    100, 500, 1000, 5000, 25000, 50000, 100000, 200000, 400000, 800000,
    1000000, 10000000, 25000000, 50000000, 80000000, 100000000, 150000000, 200000000};
  localparam logic [4:0] RATE_RST = 5'h06;
  localparam logic [4:0] RATE_LAST = 5'h11;

  localparam logic [2:0] DEPTH_RST = 3'h0;
  localparam logic [2:0] DEPTH_SEL_256K = 3'h5;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_FLUSH, ST_DONE} lcf_state_type;

  function automatic logic [18:0] depth_samples(input logic [2:0] sel);
    case (sel)
      3'h0: return 19'h00800;
      3'h1: return 19'h04000;
      3'h2: return 19'h08000;
      3'h3: return 19'h10000;
      3'h4: return 19'h20000;
      default: return 19'h40000;
    endcase
  endfunction : depth_samples
endpackage : lcf_pkg

// ===== rtl/lcf_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module lcf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } lcf_fifo_type;

  lcf_fifo_type r, n;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign in_ready = r.cnt != (AW + 1)'(DEPTH);
  assign out_valid = r.cnt != '0;
  assign out_data = mem[r.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    n = r;
    if (push) begin
      n.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
    end
    n.cnt = r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // Storage needs no reset; occupancy guards every read
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[r.wp] <= in_data;
    end
  end
endmodule : lcf_fifo
`default_nettype wire

// ===== rtl/lcf_rle.sv
`timescale 1ns/1ps
`default_nettype none
module lcf_rle (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic comp_en,
  input wire logic in_valid,
  input wire logic [31:0] in_data,
  input wire logic flush,
  output logic out_valid,
  input wire logic out_ready,
  output logic [31:0] out_data,
  output logic pend,
  output logic new_entry,
  output logic overflow
);
  import lcf_pkg::*;

  typedef struct packed {
    logic pend;
    logic [COMP_CHANNELS-1:0] cur;
    logic [RUN_WIDTH-1:0] run;
    logic ovalid;
    logic [31:0] odata;
  } lcf_rle_type;

  lcf_rle_type r, n;
  logic slot, merge, emit, emit_flush;
  logic [31:0] edata;

  assign slot = ~r.ovalid | out_ready;
  // A run closes on a changed value or a full count
  assign merge = comp_en & r.pend & (in_data[COMP_CHANNELS-1:0] == r.cur)
                 & (r.run < RUN_WIDTH'(RUN_MAX));
  assign new_entry = in_valid & ~merge;
  assign emit = in_valid & (~comp_en | (r.pend & ~merge));
  assign emit_flush = flush & comp_en & r.pend & ~in_valid & slot;
  assign edata = comp_en ? {r.run, r.cur} : in_data;
  // Incoming samples cannot wait, so a blocked slot means loss
  assign overflow = emit & ~slot;
  assign out_valid = r.ovalid;
  assign out_data = r.odata;
  assign pend = r.pend;

  always_comb begin
    n = r;
    if (r.ovalid & out_ready) begin
      n.ovalid = 1'b0;
    end
    if ((emit & slot) | emit_flush) begin
      n.ovalid = 1'b1;
      n.odata = edata;
    end
    if (comp_en & in_valid) begin
      if (merge) begin
        n.run = r.run + 1'b1;
      end else begin
        n.cur = in_data[COMP_CHANNELS-1:0];
        n.run = RUN_WIDTH'(1);
        n.pend = 1'b1;
      end
    end else if (emit_flush) begin
      n.pend = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule : lcf_rle
`default_nettype wire

// ===== rtl/lcf_capture.sv
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module lcf_capture #(
  parameter int CLK_HZ = lcf_pkg::CLK_HZ_DEF,
  parameter int MEM_WORDS = lcf_pkg::MEM_WORDS_DEF,
  parameter int FIFO_DEPTH = lcf_pkg::FIFO_DEPTH_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [lcf_pkg::GROUP_WIDTH-1:0] channel_group_a,
  input wire logic [lcf_pkg::GROUP_WIDTH-1:0] channel_group_b,
  input wire logic [lcf_pkg::GROUP_WIDTH-1:0] channel_group_c,
  input wire logic [lcf_pkg::GROUP_WIDTH-1:0] channel_group_d,
  input wire logic ext_sample_clk,
  output logic capture_busy
);
  import lcf_pkg::*;

  localparam int AW = $clog2(MEM_WORDS);

  typedef struct packed {
    lcf_state_type st;
    logic [CHANNELS-1:0] probe_s1;
    logic [CHANNELS-1:0] probe_s2;
    logic [CHANNELS-1:0] probe_d3;
    logic [2:0] eclk_sh;
    logic [31:0] div_cnt;
    logic comp_en;
    logic ext_sel;
    logic ext_fall;
    logic pause;
    logic [4:0] rate_sel;
    logic [2:0] depth_sel;
    logic [31:0] filt_ab;
    logic [31:0] filt_cd;
    logic [18:0] issue_cnt;
    logic [AW+1:0] wpos;
    logic [15:0] lo_half;
    logic ovf;
    logic [AW-1:0] mem_addr;
    logic ack;
    logic [31:0] prdata;
  } lcf_core_type;

  lcf_core_type r, n;

  function automatic logic chan_ok(input logic [1:0] cond, input logic v);
    case (cond)
      FILT_HIGH: return v;
      FILT_LOW: return ~v;
      default: return 1'b1;
    endcase
  endfunction : chan_ok

  function automatic logic filt_pass(input logic [CHANNELS-1:0] s,
                                     input logic [63:0] f);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < CHANNELS; i++) begin
      ok = ok & chan_ok(f[2*i +: 2], s[i]);
    end
    return ok;
  endfunction : filt_pass

  function automatic logic addr_hit(input logic [7:0] a);
    case (a)
      OFS_CTRL, OFS_RATE, OFS_DEPTH, OFS_FILT_AB, OFS_FILT_CD: return 1'b1;
      OFS_STATUS, OFS_COUNT, OFS_MEM_ADDR, OFS_MEM_DATA: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : addr_hit

  // Read view of the register file; unmapped offsets read as zero
  function automatic logic [31:0] reg_view(input logic [7:0] a,
                                           input lcf_core_type s,
                                           input logic empty,
                                           input logic wide_pack,
                                           input logic [31:0] q);
    case (a)
      OFS_CTRL: return {26'h0000000, s.pause, s.ext_fall, s.ext_sel, s.comp_en, 2'h0};
      OFS_RATE: return {27'h0000000, s.rate_sel};
      OFS_DEPTH: return {29'h00000000, s.depth_sel};
      OFS_FILT_AB: return s.filt_ab;
      OFS_FILT_CD: return s.filt_cd;
      OFS_STATUS: return {27'h0000000, empty, wide_pack, s.ovf, s.st};
      OFS_COUNT: return 32'(s.wpos);
      OFS_MEM_ADDR: return 32'(s.mem_addr);
      OFS_MEM_DATA: return q;
      default: return 32'h00000000;
    endcase
  endfunction : reg_view

  // Divider per menu entry; rates above pclk collapse to every cycle
  logic [31:0] div_tab [RATE_CNT];
  genvar gi;
  generate
    for (gi = 0; gi < RATE_CNT; gi++) begin : g_rate
      localparam int unsigned DIV = CLK_HZ / RATE_HZ[gi];
      assign div_tab[gi] = (DIV > 0) ? 32'(DIV) : 32'h00000001;
    end
  endgenerate

  logic acc, wr_go, busy, narrow, comp_act, int_tick, ext_edge, tick;
  logic accept, drained, tail, pop, mem_we;
  logic [CHANNELS-1:0] sample, masked;
  logic [18:0] limit;
  logic [AW-1:0] mem_waddr;
  logic [31:0] mem_wdata, mem_q_r;
  logic rle_new, rle_pend, rle_ov, rle_valid, fifo_ready, fifo_valid;
  logic [31:0] rle_data, fifo_data;
  logic [31:0] mem [MEM_WORDS];

  assign acc = psel & penable;
  assign wr_go = acc & r.ack & pwrite;
  assign busy = (r.st == ST_RUN) | (r.st == ST_FLUSH);
  assign narrow = r.depth_sel == DEPTH_SEL_256K;
  assign comp_act = r.comp_en & ~narrow;
  assign limit = depth_samples(r.depth_sel);

  assign int_tick = r.div_cnt >= (div_tab[r.rate_sel] - 32'h00000001);
  assign ext_edge = r.ext_fall ? (r.eclk_sh[2] & ~r.eclk_sh[1])
                               : (~r.eclk_sh[2] & r.eclk_sh[1]);
  assign tick = r.ext_sel ? ext_edge : int_tick;
  // Extra stage keeps data aligned with the delayed edge detect
  assign sample = r.ext_sel ? r.probe_d3 : r.probe_s2;
  assign masked = narrow ? {16'h0000, sample[NARROW_CHANNELS-1:0]}
                : comp_act ? {8'h00, sample[COMP_CHANNELS-1:0]} : sample;

  assign accept = (r.st == ST_RUN) & tick & (r.issue_cnt < limit)
                  & filt_pass(sample, {r.filt_cd, r.filt_ab});

  lcf_rle u_rle (
    .pclk(pclk),
    .presetn(presetn),
    .comp_en(comp_act),
    .in_valid(accept),
    .in_data(masked),
    .flush(r.st == ST_FLUSH),
    .out_valid(rle_valid),
    .out_ready(fifo_ready),
    .out_data(rle_data),
    .pend(rle_pend),
    .new_entry(rle_new),
    .overflow(rle_ov)
  );

  lcf_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(rle_valid),
    .in_ready(fifo_ready),
    .in_data(rle_data),
    .out_valid(fifo_valid),
    .out_ready(~r.pause),
    .out_data(fifo_data)
  );

  // Even 256K samples wait in the low half for their partner
  logic half_wait;
  assign half_wait = narrow & ~r.wpos[0];

  // Only entries that reach the writer, and the 256K tail write in flush, move the position
  assign pop = fifo_valid & ~r.pause;
  assign drained = ~rle_pend & ~rle_valid & ~fifo_valid;
  assign tail = (r.st == ST_FLUSH) & drained & narrow & r.wpos[0];
  assign mem_we = (pop & ~half_wait) | tail;
  assign mem_waddr = narrow ? r.wpos[AW:1] : r.wpos[AW-1:0];
  assign mem_wdata = tail ? {16'h0000, r.lo_half}
                   : narrow ? {fifo_data[15:0], r.lo_half} : fifo_data;

  assign prdata = r.prdata;
  assign pready = r.ack;
  assign pslverr = r.ack & ~addr_hit(paddr);
  assign capture_busy = busy;

  // Write decodes shared by the config, start, stop and pause paths
  logic ctrl_wr, start_wr, stop_wr, maddr_wr, cfg_wr;
  assign ctrl_wr = wr_go & (paddr == OFS_CTRL);
  assign start_wr = ctrl_wr & pwdata[CTRL_START];
  assign stop_wr = ctrl_wr & pwdata[CTRL_STOP];
  assign maddr_wr = wr_go & (paddr == OFS_MEM_ADDR);
  assign cfg_wr = wr_go & ~busy;

  always_comb begin
    n = r;
    n.probe_s1 = {channel_group_d, channel_group_c, channel_group_b, channel_group_a};
    n.probe_s2 = r.probe_s1;
    n.probe_d3 = r.probe_s2;
    n.eclk_sh = {r.eclk_sh[1:0], ext_sample_clk};

    // Fixed single wait state; the latched word stands with pready
    n.ack = acc & ~r.ack;
    if (acc & ~r.ack) begin
      n.prdata = reg_view(paddr, r, ~fifo_valid, narrow, mem_q_r);
    end

    if (r.st == ST_RUN) begin
      n.div_cnt = int_tick ? 32'h00000000 : r.div_cnt + 32'h00000001;
    end else begin
      n.div_cnt = 32'h00000000;
    end

    if (rle_new) begin
      n.issue_cnt = r.issue_cnt + 19'h00001;
    end

    if (pop) begin
      n.wpos = r.wpos + 1'b1;
      if (half_wait) begin
        n.lo_half = fifo_data[15:0];
      end
    end

    // Mode changes mid-capture would corrupt stored entries, so CTRL mode, RATE, DEPTH and filter writes are dropped while busy
    if (cfg_wr) begin
      unique case (paddr)
        OFS_CTRL: begin
          n.comp_en = pwdata[CTRL_COMP];
          n.ext_sel = pwdata[CTRL_EXT];
          n.ext_fall = pwdata[CTRL_FALL];
          n.pause = pwdata[CTRL_PAUSE];
        end
        OFS_RATE: n.rate_sel = (pwdata[4:0] > RATE_LAST) ? RATE_LAST : pwdata[4:0];
        OFS_DEPTH: n.depth_sel = (pwdata[2:0] > DEPTH_SEL_256K) ? DEPTH_SEL_256K
                                                                  : pwdata[2:0];
        OFS_FILT_AB: n.filt_ab = pwdata;
        OFS_FILT_CD: n.filt_cd = pwdata;
        default: n.mem_addr = r.mem_addr;
      endcase
    end

    if (maddr_wr) begin
      n.mem_addr = pwdata[AW-1:0];
    end

    // Pause stays writable while busy so software can throttle the writer
    if (ctrl_wr & busy) begin
      n.pause = pwdata[CTRL_PAUSE];
    end

    unique case (r.st)
      ST_IDLE, ST_DONE: begin
        if (start_wr) begin
          n.st = ST_RUN;
          n.issue_cnt = 19'h00000;
          n.wpos = '0;
          n.ovf = 1'b0;
        end
      end
      ST_RUN: begin
        if (stop_wr | (r.issue_cnt >= limit)) begin
          n.st = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        if (drained) begin
          n.st = ST_DONE;
          if (tail) begin
            n.wpos = r.wpos + 1'b1;
          end
        end
      end
    endcase

    // Loss flag set after the start clear so an event is never dropped
    if (rle_ov) begin
      n.ovf = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.rate_sel <= RATE_RST;
      r.depth_sel <= DEPTH_RST;
      r.filt_ab <= FILT_RST;
      r.filt_cd <= FILT_RST;
    end else begin
      r <= n;
    end
  end

  // Capture store, one word per entry, or per two entries in 256K mode
  always_ff @(posedge pclk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
    end
    mem_q_r <= mem[r.mem_addr];
  end
endmodule : lcf_capture
`default_nettype wire

// ===== testbench/lcf_capture_checker.sv
`timescale 1ns/1ps
`default_nettype none
module lcf_capture_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic capture_busy
);
  import lcf_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic bad;
  // Off-grid or past the last word
  assign bad = (paddr > OFS_MEM_DATA) || (paddr[1:0] != 2'h0);
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  wait_state_a: assert property (setup_s ##1 access_s |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  ready_cause_a: assert property (pready |-> psel && penable && $past(psel && penable)
    && $past(psel && !penable, 2))
    else $error("pready without setup and access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_gate_a: assert property (pslverr |-> pready)
    else $error("pslverr outside pready");
  unmapped_err_a: assert property (pready && bad |-> pslverr)
    else $error("unmapped access without error");
  mapped_ok_a: assert property (pready && !bad |-> !pslverr)
    else $error("mapped access flagged");
  unmapped_zero_a: assert property (pready && !pwrite && bad |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  busy_start_a: assert property ($rose(capture_busy) |->
    $past(pready && pwrite && paddr == OFS_CTRL && pwdata[CTRL_START]))
    else $error("capture began without start write");
endmodule : lcf_capture_checker
bind lcf_capture lcf_capture_checker chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .capture_busy(capture_busy));
`default_nettype wire

// ===== testbench/lcf_probe_model.sv
`timescale 1ns/1ps
`default_nettype none
module lcf_probe_model (
  input wire logic pclk,
  input wire logic [31:0] level,
  input wire logic go,
  input wire logic [9:0] toggles,
  output logic [7:0] grp_a,
  output logic [7:0] grp_b,
  output logic [7:0] grp_c,
  output logic [7:0] grp_d,
  output logic ext_clk,
  output logic busy
);
  initial ext_clk = 1'b0;
  initial busy = 1'b0;
  assign {grp_d, grp_c, grp_b, grp_a} = level;
  // Clock parks between frames; four-cycle half period stays under pclk/4
  always @(posedge pclk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      for (int i = 0; i < toggles; i++) begin
        repeat (4) @(posedge pclk);
        ext_clk <= ~ext_clk;
      end
      repeat (8) @(posedge pclk);
      busy <= 1'b0;
    end
  end
endmodule : lcf_probe_model
`default_nettype wire

// ===== testbench/lcf_capture_bench.sv
`timescale 1ns/1ps
`default_nettype none
module lcf_capture_bench;
  import lcf_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] level = 32'h0;
  logic go = 1'b0;
  logic [9:0] toggles = 10'h000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, capture_busy, ext_clk, pm_busy, er;
  logic [7:0] ga, gb, gc, gd;
  int err_count = 0;
  int check_count = 0;
  // Filter AB, filter CD, probe, stored count
  logic [31:0] tab [8][4] = '{
    '{32'h0, 32'h0, 32'hA5A55A5A, 32'h5},
    '{32'h1, 32'h0, 32'h00000001, 32'h5},
    '{32'h1, 32'h0, 32'hFFFFFFFE, 32'h0},
    '{32'h80000000, 32'h0, 32'hFFFF7FFF, 32'h5},
    '{32'h80000000, 32'h0, 32'h00008000, 32'h0},
    '{32'h0, 32'h40000000, 32'h80000000, 32'h5},
    '{32'h0, 32'h2, 32'h00010000, 32'h0},
    '{32'hFFFFFFFF, 32'h0, 32'h3C3C3C3C, 32'h5}};
  logic [7:0] ra [5] = '{OFS_RATE, OFS_DEPTH, OFS_FILT_AB, OFS_FILT_CD, OFS_STATUS};
  logic [31:0] rv [5] = '{32'h6, 32'h0, 32'h0, 32'h0, 32'h10};

  always #4 pclk = ~pclk;

  lcf_capture #(.CLK_HZ(10000), .MEM_WORDS(4096), .FIFO_DEPTH(32)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .channel_group_a(ga), .channel_group_b(gb), .channel_group_c(gc),
    .channel_group_d(gd), .ext_sample_clk(ext_clk), .capture_busy(capture_busy));

  lcf_probe_model PM (.pclk(pclk), .level(level), .go(go), .toggles(toggles),
    .grp_a(ga), .grp_b(gb), .grp_c(gc), .grp_d(gd), .ext_clk(ext_clk), .busy(pm_busy));

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task test_done;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task mem(input logic [31:0] a);
    apb(1'b1, OFS_MEM_ADDR, a);
    apb(1'b0, OFS_MEM_DATA, 32'h0);
  endtask : mem

  // Start, let edges or time pass, stop, wait for done, leave COUNT in rd
  task run(input logic [31:0] c, input logic [9:0] t, input int w);
    int n;
    apb(1'b1, OFS_CTRL, c);
    toggles <= t;
    go <= (t != 10'h000);
    @(posedge pclk);
    go <= 1'b0;
    chk("busy", {31'h0, capture_busy}, 32'h1);
    repeat (w) @(posedge pclk);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pm_busy && n < 5000);
    if (n >= 5000) err_count++;
    apb(1'b1, OFS_CTRL, 32'h2);
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0);
      n++;
    end while (rd[1:0] !== 2'h3 && n < 100);
    if (n >= 100) err_count++;
    apb(1'b0, OFS_COUNT, 32'h0);
  endtask : run

  initial begin
    repeat (40000) @(posedge pclk);
    err_count++;
    test_done();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, OFS_FILT_AB, tab[i][0]);
      apb(1'b1, OFS_FILT_CD, tab[i][1]);
      level <= tab[i][2];
      run(32'h9, 10'h00A, 0);
      chk("row count", rd, tab[i][3]);
      if (tab[i][3] != 32'h0) begin
        mem(32'h0);
        chk("row word", rd, tab[i][2]);
      end
    end
    // 256 equal samples need two entries
    level <= 32'hC3A55A3C;
    run(32'hD, 10'h200, 0);
    chk("comp count", rd, 32'h2);
    mem(32'h0);
    chk("comp word0", rd, 32'hFFA55A3C);
    mem(32'h1);
    chk("comp word1", rd, 32'h01A55A3C);
    // Nine toggles from low give four falling edges
    run(32'h19, 10'h009, 0);
    chk("fall count", rd, 32'h4);
    // 256K mode keeps 16 channels, two samples per word
    apb(1'b1, OFS_DEPTH, 32'h5);
    run(32'h9, 10'h008, 0);
    chk("pack count", rd, 32'h4);
    mem(32'h0);
    chk("pack word", rd, 32'h5A3C5A3C);
    apb(1'b1, OFS_DEPTH, 32'h0);
    apb(1'b1, OFS_RATE, 32'h11);
    run(32'h1, 10'h000, 2200);
    chk("depth count", rd, 32'h800);
    // Paused writer: FIFO fills, overflows, then drains on stop
    run(32'h21, 10'h000, 100);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("fifo status", rd & 32'h14, 32'h14);
    apb(1'b1, OFS_RATE, 32'h0);
    run(32'h1, 10'h000, 1000);
    chk("rate count", {31'h0, rd >= 32'h9 && rd <= 32'hB}, 32'h1);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset value", rd, rv[i]);
    end
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped err", {31'h0, er}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    test_done();
  end
endmodule : lcf_capture_bench
`default_nettype wire
